// file: hw/dsw_loader.sv

`timescale 1ns/1ns
`default_nettype none

`include "dsw_defs.svh"

module dsw_loader
  import dsw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial pins from the host
  input wire logic frame_sel_n_in,
  input wire logic sclk_in,
  input wire logic serial_data_in,
  // converter side
  output var logic [`DSW_CODE_W-1:0] code_out,
  output var logic [1:0] mode_out,
  output var logic power_down_out,
  // word events
  output var logic load_out,
  output var logic abort_out
);

  // ********************************************************************
  // pin synchroniser
  // ********************************************************************

  dsw_pins_s pin_raw;
  dsw_pins_s pin_meta_q;
  dsw_pins_s pin_sync_q;
  logic sclk_prev_q;

  assign pin_raw = '{frame_n: frame_sel_n_in, sclk: sclk_in,
                     sdata: serial_data_in};

  // two flops per pin, idle level after reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= `DSW_PIN_IDLE;
      pin_sync_q <= `DSW_PIN_IDLE;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // previous serial clock level for edge finding
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= pin_sync_q.sclk;
    end
  end

  // ********************************************************************
  // decode of pins and state
  // ********************************************************************

  dsw_state_e state_q;
  dsw_state_e state_d;
  logic [`DSW_CNT_W-1:0] cnt_q;
  logic [`DSW_CNT_W-1:0] cnt_d;
  logic [`DSW_WORD_W-1:0] shreg_q;
  logic [`DSW_WORD_W-1:0] shreg_d;
  logic [`DSW_WORD_W-1:0] word_full;
  dsw_word_s word_now;
  wire framed;
  wire sclk_fall;
  wire in_frame_state;
  wire shift_en;
  wire exec;
  wire abort;

  // framing and clock edge
  assign framed = ~pin_sync_q.frame_n;
  assign sclk_fall = sclk_prev_q & ~pin_sync_q.sclk;
  assign in_frame_state = (state_q == DSW_ST_IDLE) || (state_q == DSW_ST_SHIFT);
  // edges count only inside an open frame
  assign shift_en = framed & sclk_fall & in_frame_state;
  // sixteenth edge executes the word
  assign exec = shift_en & (cnt_q == `DSW_LAST_BIT);
  // early rise of frame select drops the word
  assign abort = (state_q == DSW_ST_SHIFT) & ~framed;

  // word as it stands once the current bit is in, msb first
  assign word_full = {shreg_q[`DSW_WORD_W-2:0], pin_sync_q.sdata};
  assign word_now = dsw_word_s'(word_full);

  // ********************************************************************
  // frame state machine
  // ********************************************************************

  // next state from framing and edges
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DSW_ST_IDLE: begin
        if (framed) begin
          state_d = DSW_ST_SHIFT;
        end
        if (exec) begin
          state_d = DSW_ST_DONE;
        end
      end
      DSW_ST_SHIFT: begin
        if (!framed) begin
          state_d = DSW_ST_IDLE;
        end else if (exec) begin
          state_d = DSW_ST_DONE;
        end
      end
      DSW_ST_DONE: begin
        if (!framed) begin
          state_d = DSW_ST_IDLE;
        end
      end
      default: begin
        state_d = DSW_ST_DONE;
      end
    endcase
  end

  // reset parks in done, but the synchroniser's idle reset level reads as a high frame, so idle follows at once
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= DSW_ST_DONE;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************************
  // bit counter and shift register
  // ********************************************************************

  // counter clears outside a frame, on abort and on execution
  always_comb begin
    cnt_d = cnt_q;
    if (!framed || !in_frame_state) begin
      cnt_d = `DSW_CNT_RST;
    end else if (exec) begin
      cnt_d = `DSW_CNT_RST;
    end else if (shift_en) begin
      cnt_d = cnt_q + `DSW_CNT_W'(1);
    end
  end

  // shift register clears on abort, shifts on counted edges
  always_comb begin
    shreg_d = shreg_q;
    if (abort) begin
      shreg_d = `DSW_SHIFT_RST;
    end else if (shift_en) begin
      shreg_d = word_full;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= `DSW_CNT_RST;
      shreg_q <= `DSW_SHIFT_RST;
    end else begin
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
    end
  end

  // ********************************************************************
  // code register and mode
  // ********************************************************************

  // load on execution only, power-down words included; abort leaves both alone
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      code_out <= `DSW_CODE_RST;
      mode_out <= DSW_MODE_NORMAL;
      power_down_out <= 1'b0;
    end else if (exec) begin
      code_out <= word_now.code;
      mode_out <= word_now.mode;
      power_down_out <= (word_now.mode != DSW_MODE_NORMAL);
    end
  end

  // one-cycle word events
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      load_out <= 1'b0;
      abort_out <= 1'b0;
    end else begin
      load_out <= exec;
      abort_out <= abort;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************

  default clocking dsw_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic [`DSW_WORD_W-2:0] shreg_low;
  logic sdata_now;
  assign shreg_low = shreg_q[`DSW_WORD_W-2:0];
  assign sdata_now = pin_sync_q.sdata;

  shift_step_a: assert property (
    shift_en && !exec |=> shreg_q == {$past(shreg_low), $past(sdata_now)})
    else $error("shift register did not take the sampled bit");

  exec_load_a: assert property (
    exec |=> load_out && code_out == $past(word_now.code))
    else $error("sixteenth edge did not load the code");

  mode_decode_a: assert property (
    exec |=> mode_out == $past(word_full[`DSW_MODE_HI:`DSW_MODE_LO]))
    else $error("mode not taken from the first two bits");

  pd_flag_a: assert property (
    power_down_out == (mode_out != 2'h0))
    else $error("power-down flag disagrees with mode");

  abort_clear_a: assert property (
    abort |=> shreg_q == `DSW_SHIFT_RST && cnt_q == `DSW_CNT_RST && abort_out)
    else $error("aborted word not cleared");

  abort_hold_a: assert property (
    abort |=> $stable(code_out) && $stable(mode_out) ##1 !load_out)
    else $error("aborted word changed code or mode");

  code_hold_a: assert property (
    !exec |=> $stable(code_out) && $stable(mode_out))
    else $error("code or mode changed without a word");

  idle_cnt_a: assert property (
    !framed |=> cnt_q == `DSW_CNT_RST && !load_out)
    else $error("counter not clear while frame high");

  done_ignore_a: assert property (
    state_q == DSW_ST_DONE && sclk_fall |=> $stable(shreg_q) ##1 !load_out)
    else $error("edge after execution was not ignored");

  after_exec_a: assert property (
    exec |=> state_q == DSW_ST_DONE ##1 !load_out[*2])
    else $error("word executed more than once");

  load_pulse_a: assert property (
    load_out |=> !load_out)
    else $error("load event longer than one cycle");

  abort_pulse_a: assert property (
    abort_out |=> !abort_out)
    else $error("abort event longer than one cycle");

  // code and mode move only together with a load event
  code_change_a: assert property (
    $changed(code_out) || $changed(mode_out) |-> load_out)
    else $error("code or mode changed without a load event");

  count_step_a: assert property (
    shift_en && !exec |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit counter did not step on a counted edge");

  done_hold_a: assert property (
    state_q == DSW_ST_DONE && framed |=> state_q == DSW_ST_DONE)
    else $error("frame reopened without frame select going high");

  frame_open_a: assert property (
    !framed |=> state_q != DSW_ST_SHIFT)
    else $error("frame held open while frame select high");

  // reset itself is the trigger here, so the default disable must not apply
  reset_zero_a: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_n_in |=> code_out == `DSW_CODE_RST && mode_out == 2'h0 && !load_out)
    else $error("reset did not give zero code");

endmodule

`default_nettype wire

// file: hw/dsw_defs.svh
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH

// ********************************************************************
// word layout
// ********************************************************************
`define DSW_WORD_W 16
`define DSW_CODE_W 14
`define DSW_MODE_HI 15
`define DSW_MODE_LO 14
`define DSW_CODE_HI 13

// ********************************************************************
// counts and reset values
// ********************************************************************
`define DSW_CNT_W 4
`define DSW_LAST_BIT 4'hF
`define DSW_CNT_RST 4'h0
`define DSW_CODE_RST 14'h0000
`define DSW_SHIFT_RST 16'h0000
`define DSW_FULL_SCALE 16384

// ********************************************************************
// pin sampling
// ********************************************************************
`define DSW_PIN_W 3
`define DSW_PIN_IDLE 3'h7

`endif

// file: hw/dsw_pkg.sv
`include "dsw_defs.svh"

package dsw_pkg;

  // operating mode carried by the two upper bits of a word
  typedef enum logic [1:0] {
    DSW_MODE_NORMAL = 2'h0,
    DSW_MODE_PD_1K = 2'h1,
    DSW_MODE_PD_100K = 2'h2,
    DSW_MODE_PD_TRI = 2'h3
  } dsw_mode_e;

  // frame tracking states, gray along idle-shift-done
  typedef enum logic [1:0] {
    DSW_ST_IDLE = 2'h0,
    DSW_ST_SHIFT = 2'h1,
    DSW_ST_DONE = 2'h3
  } dsw_state_e;

  // one received word split into its fields
  typedef struct packed {
    dsw_mode_e mode;
    logic [`DSW_CODE_W-1:0] code;
  } dsw_word_s;

  // the three serial pins after sampling
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdata;
  } dsw_pins_s;

endpackage

// file: bench/dsw_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// host side of the serial link
// ****************************************
module dsw_host_model (
  // bench clock
  input wire logic clk_in,
  // serial pins towards the loader
  output var logic frame_sel_n_out,
  output var logic sclk_out,
  output var logic sdata_out
);
  // idle with frame high, clock parked
  initial begin
    frame_sel_n_out = 1'b1;
    sclk_out = 1'b1;
    sdata_out = 1'b0;
  end

  // one 400 ns serial clock period: data at the rise, fall, rise
  task automatic pulse(input logic bit_v);
    sdata_out <= bit_v;
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b1;
  endtask

  // one frame: falls while high, n bits msb first, extra falls, release or idle low
  task automatic send(input logic [15:0] w, input int n, input int extra, input int pre,
                      input bit idle_low);
    int i;
    @(posedge clk_in);
    frame_sel_n_out <= 1'b1;
    for (i = 0; i < pre; i++) begin
      pulse(w[i % 16]);
    end
    repeat (3) @(posedge clk_in);
    frame_sel_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (i = 0; i < n + extra; i++) begin
      pulse((i < 16) ? w[15 - i] : ~w[i % 16]);
    end
    repeat (3) @(posedge clk_in);
    frame_sel_n_out <= idle_low ? 1'b0 : 1'b1;
  endtask
endmodule

`default_nettype wire

// file: bench/dsw_loader_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`include "dsw_defs.svh"

// ****************************************
// loader bench
// ****************************************
module dsw_loader_tb_top
  import dsw_pkg::*;
;
  logic clk_in, rst_n_in;
  wire logic frame_n, sclk, sdata;
  logic [`DSW_CODE_W-1:0] code;
  logic [1:0] mode;
  logic pd, load, abort;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [13:0] cur_code;
  logic [1:0] cur_mode;
  logic [31:0] r;
  int failures, num_checks, i;

  dsw_host_model u_dsw_host_model (
    .clk_in(clk_in),
    .frame_sel_n_out(frame_n),
    .sclk_out(sclk),
    .sdata_out(sdata)
  );

  dsw_loader u_dsw_loader (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .frame_sel_n_in(frame_n),
    .sclk_in(sclk),
    .serial_data_in(sdata),
    .code_out(code),
    .mode_out(mode),
    .power_down_out(pd),
    .load_out(load),
    .abort_out(abort)
  );

  // 20 mhz clock
  always #25 clk_in = ~clk_in;

  // compare and count
  task check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // note the expected outcome, then play the frame
  task word(input logic [1:0] m, input logic [13:0] c, input int n, input int extra,
            input int pre, input bit idle_low);
    if (n == 16) begin
      cur_mode = m;
      cur_code = c;
    end
    exp_q.push_back({n < 16, cur_mode, cur_code});
    u_dsw_host_model.send({m, c}, n, extra, pre, idle_low);
  endtask

  // takes the oldest note at each load or abort pulse
  always @(negedge clk_in) begin
    if (rst_n_in === 1'b1 && (load === 1'b1 || abort === 1'b1)) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("Error at %0t: unexpected word event", $time);
      end else begin
        e = exp_q.pop_front();
        check({abort, pd, mode, code}, {e[16], e[15:14] != 2'h0, e[15:0]});
      end
    end
  end

  // main sequence
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    failures = 0;
    num_checks = 0;
    cur_mode = 2'h0;
    cur_code = 14'h0000;
    void'($urandom(32'h78D0));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    check({abort, pd, mode, code}, 18'h00000);
    word(2'h0, 14'h1555, 15, 0, 0, 1'b0);
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      word(i[1:0], r[13:0], 16, 0, 0, 1'b0);
    end
    word(2'h3, 14'h0000, 1, 0, 0, 1'b0);
    word(2'h0, 14'h3FFF, 16, 3, 0, 1'b1);
    word(2'h0, 14'h2000, 16, 0, 2, 1'b0);
    for (i = 0; i < 100 && exp_q.size() > 0; i++) begin
      @(negedge clk_in);
    end
    if (exp_q.size() != 0) begin
      failures++;
      $display("Error at %0t: words not executed", $time);
    end
    results();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    $display("Error at %0t: timeout", $time);
    results();
  end
endmodule

`default_nettype wire
